// >>> rtl/twrp_map.svh
// Purpose: Constants for the two-wire register port
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef TWRP_MAP_SVH
`define TWRP_MAP_SVH

// =====================================================
// Register space
`define TWRP_REG_LAST      7'h1F
`define TWRP_REG_DEPTH     32
`define TWRP_REG_AW        5
`define TWRP_REG_DEFAULT   8'h00

// =====================================================
// Serial framing
`define TWRP_RW_READ       1'h1
`define TWRP_BITS_DONE     4'h8
`define TWRP_TX_LAST       4'h7

// =====================================================
// Input filter timing
`define TWRP_FILT_NS       50
`define TWRP_LINK_MHZ      83
`define TWRP_FILT_CYC      ((`TWRP_FILT_NS * `TWRP_LINK_MHZ + 999) / 1000)

`endif

// >>> rtl/twrp_pkg.sv
// Purpose: Types for the two-wire register port
// Assumes: Constants live in twrp_map.svh
// Notes:   One-hot state codes
package twrp_pkg;

	typedef logic [7:0] twrp_byte_t;
	typedef logic [6:0] twrp_ptr_t;

	typedef enum logic [8:0]
	{
		TWRP_IDLE      = 9'h001,
		TWRP_ADDR      = 9'h002,
		TWRP_ADDR_ACK  = 9'h004,
		TWRP_PTR       = 9'h008,
		TWRP_PTR_ACK   = 9'h010,
		TWRP_WDATA     = 9'h020,
		TWRP_WDATA_ACK = 9'h040,
		TWRP_RDATA     = 9'h080,
		TWRP_RDATA_ACK = 9'h100
	} twrp_state_e;

endpackage : twrp_pkg

// >>> rtl/twrp_regmem.sv
// Purpose: Control register storage, one write and two read ports
// Assumes: Single clock, active-low async reset
// Notes:   Read data are registered
`timescale 1ns/100ps
`include "twrp_map.svh"

module twrp_regmem
(
	input  wire logic                       i_clock,     // Core clock
	input  wire logic                       i_rstn,      // Synced reset
	input  wire logic                       i_wr_en,     // Write strobe
	input  wire logic [`TWRP_REG_AW-1:0]    i_a_addr,    // Port A address
	input  wire twrp_pkg::twrp_byte_t       i_wr_data,   // Write data
	output twrp_pkg::twrp_byte_t            o_a_data,    // Port A read data
	input  wire logic [`TWRP_REG_AW-1:0]    i_b_addr,    // Port B address
	output twrp_pkg::twrp_byte_t            o_b_data     // Port B read data
);
	import twrp_pkg::*;

	twrp_byte_t mem_r [`TWRP_REG_DEPTH];

	// =====================================================
	// Storage, defaults on reset
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			for (int i = 0; i < `TWRP_REG_DEPTH; i++)
				mem_r[i] <= `TWRP_REG_DEFAULT;
		end
		else if (i_wr_en)
			mem_r[i_a_addr] <= i_wr_data;
	end

	// =====================================================
	// Registered reads
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_a_data <= `TWRP_REG_DEFAULT;
			o_b_data <= `TWRP_REG_DEFAULT;
		end
		else
		begin
			o_a_data <= mem_r[i_a_addr];
			o_b_data <= mem_r[i_b_addr];
		end
	end

endmodule : twrp_regmem

// >>> rtl/twrp_top.sv
// Purpose: Two-wire serial slave port onto the control registers
// Assumes: i_link_clock free-running sampler, SCL well below it
// Notes:   Serial engine on link clock, registers on i_clock
// Overview of operation
// - Answer one of two addresses, read and write
// - Address byte LSB one reads, zero writes
// - Address bit one follows the strap pin
// - Strap high filters pulses under 50 ns
// - SDA fall with SCL high starts transfer
// - Seven address bits then direction, MSB first
// - Own address acknowledged low on ninth clock
// - Foreign address releases bus, wait for Start
// - Second byte is pointer, then autoincrement
// - Start or Stop anywhere forces idle/restart
// - Nonexistent pointer gets no acknowledge, idle
// - Read past top repeats highest register
// - Write past top discarded, no-acknowledge, idle
// - Pointer write-only, other registers read/write
// - Writes start by loading the pointer, reads use the stored pointer
// - Reset low loads every register default
`timescale 1ns/100ps
`include "twrp_map.svh"

module twrp_top
#(
	parameter logic [6:0] P_ADDR_BASE = 7'h2C            // Slave address, bit one from strap
)
(
	input  wire logic                       i_clock,              // Core clock, 100 MHz
	input  wire logic                       i_resetn,             // Async reset, active low
	input  wire logic                       i_link_clock,         // Link sampling clock
	input  wire logic                       i_scl,                // Serial clock pin
	input  wire logic                       i_sda,                // Serial data pin, input side
	output logic                            o_sda_out,            // Serial data pin, output side
	output logic                            o_sda_oe_n,           // Low while pulling data low
	input  wire logic                       i_address_strap_pin,  // Address bit one and filter on
	input  wire logic [`TWRP_REG_AW-1:0]    i_core_addr,          // Encoder register select
	output twrp_pkg::twrp_byte_t            o_core_data           // Encoder register contents
);
	import twrp_pkg::*;

	// =====================================================
	// Reset release, one copy per domain
	logic [1:0] crst_r;
	logic [1:0] lrst_r;
	logic       core_rstn;
	logic       link_rstn;

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			crst_r <= 2'h0;
		else
			crst_r <= {crst_r[0], 1'h1};
	end

	always_ff @(posedge i_link_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			lrst_r <= 2'h0;
		else
			lrst_r <= {lrst_r[0], 1'h1};
	end

	assign core_rstn = crst_r[1];
	assign link_rstn = lrst_r[1];

	// =====================================================
	// Pin synchronisers and glitch filter
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [1:0] line_r;
	logic [1:0] prev_r;
	logic [2:0] filt_cnt_r [2];
	logic       strap;

	always_ff @(posedge i_link_clock or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			pin_s1_r <= 3'h3;
			pin_s2_r <= 3'h3;
		end
		else
		begin
			pin_s1_r <= {i_address_strap_pin, i_sda, i_scl};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign strap = pin_s2_r[2];

	always_ff @(posedge i_link_clock or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			line_r <= 2'h3;
			prev_r <= 2'h3;
			for (int i = 0; i < 2; i++)
				filt_cnt_r[i] <= 3'h0;
		end
		else
		begin
			prev_r <= line_r;
			for (int i = 0; i < 2; i++)
			begin
				if (!strap || pin_s2_r[i] == line_r[i])
				begin
					line_r[i]     <= pin_s2_r[i];
					filt_cnt_r[i] <= 3'h0;
				end
				else if (filt_cnt_r[i] == 3'(`TWRP_FILT_CYC - 1))
				begin
					line_r[i]     <= pin_s2_r[i];
					filt_cnt_r[i] <= 3'h0;
				end
				else
					filt_cnt_r[i] <= filt_cnt_r[i] + 3'h1;
			end
		end
	end

	// =====================================================
	// Bus conditions
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	assign scl_rise   = line_r[0] & ~prev_r[0];
	assign scl_fall   = ~line_r[0] & prev_r[0];
	assign start_cond = line_r[0] & prev_r[0] & prev_r[1] & ~line_r[1];
	assign stop_cond  = line_r[0] & prev_r[0] & ~prev_r[1] & line_r[1];

	// =====================================================
	// Pointer helpers
	function automatic logic ptr_valid(input twrp_ptr_t p);
		return p <= `TWRP_REG_LAST;
	endfunction : ptr_valid

	function automatic twrp_ptr_t ptr_inc(input twrp_ptr_t p);
		return ptr_valid(p) ? p + 7'h01 : p;
	endfunction : ptr_inc

	function automatic logic [`TWRP_REG_AW-1:0] ptr_sat(input twrp_ptr_t p);
		return ptr_valid(p) ? p[`TWRP_REG_AW-1:0] : `TWRP_REG_AW'(`TWRP_REG_LAST);
	endfunction : ptr_sat

	// =====================================================
	// Serial engine
	twrp_state_e state_r;
	logic [3:0]  bit_cnt_r;
	twrp_byte_t  shift_r;
	twrp_ptr_t   ptr_r;
	logic        rw_r;
	logic        drive_r;
	logic        mack_r;
	logic        rx_step;
	logic        byte_done;
	logic        addr_match;
	logic        cond;
	logic        rd_fire;
	logic        wr_fire;
	logic        busy;
	logic [`TWRP_REG_AW-1:0] rd_addr;
	twrp_byte_t  rd_hold_r;

	assign cond       = start_cond | stop_cond;
	assign rx_step    = scl_rise & (state_r == TWRP_ADDR || state_r == TWRP_PTR || state_r == TWRP_WDATA);
	assign byte_done  = scl_fall & (bit_cnt_r == `TWRP_BITS_DONE);
	assign addr_match = shift_r[7:1] == {P_ADDR_BASE[6:2], strap, P_ADDR_BASE[0]};
	assign rd_fire    = ~cond & ((state_r == TWRP_ADDR && byte_done && addr_match && shift_r[0])
	                  | (state_r == TWRP_RDATA && scl_fall && bit_cnt_r == `TWRP_TX_LAST));
	assign wr_fire    = ~cond & (state_r == TWRP_WDATA) & byte_done & ptr_valid(ptr_r);
	assign rd_addr    = (state_r == TWRP_RDATA) ? ptr_sat(ptr_inc(ptr_r)) : ptr_sat(ptr_r);

	always_ff @(posedge i_link_clock or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			state_r   <= TWRP_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			ptr_r     <= 7'h00;
			rw_r      <= 1'h0;
			drive_r   <= 1'h0;
			mack_r    <= 1'h0;
		end
		else if (start_cond)
		begin
			state_r   <= TWRP_ADDR;
			bit_cnt_r <= 4'h0;
			drive_r   <= 1'h0;
		end
		else if (stop_cond)
		begin
			state_r <= TWRP_IDLE;
			drive_r <= 1'h0;
		end
		else
		begin
			if (rx_step)
			begin
				shift_r   <= {shift_r[6:0], line_r[1]};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
			case (state_r)
				TWRP_IDLE: ;
				TWRP_ADDR:
					if (byte_done)
					begin
						if (addr_match)
						begin
							rw_r    <= shift_r[0];
							state_r <= TWRP_ADDR_ACK;
							drive_r <= 1'h1;
						end
						else
							state_r <= TWRP_IDLE;
					end
				TWRP_ADDR_ACK:
					if (scl_fall)
					begin
						bit_cnt_r <= 4'h0;
						if (rw_r == `TWRP_RW_READ)
						begin
							state_r <= TWRP_RDATA;
							shift_r <= rd_hold_r;
							drive_r <= ~rd_hold_r[7];
						end
						else
						begin
							state_r <= TWRP_PTR;
							drive_r <= 1'h0;
						end
					end
				TWRP_PTR:
					if (byte_done)
					begin
						if (ptr_valid(shift_r[6:0]))
						begin
							ptr_r   <= shift_r[6:0];
							state_r <= TWRP_PTR_ACK;
							drive_r <= 1'h1;
						end
						else
							state_r <= TWRP_IDLE;
					end
				TWRP_PTR_ACK, TWRP_WDATA_ACK:
					if (scl_fall)
					begin
						state_r   <= TWRP_WDATA;
						bit_cnt_r <= 4'h0;
						drive_r   <= 1'h0;
					end
				TWRP_WDATA:
					if (byte_done)
					begin
						if (ptr_valid(ptr_r))
						begin
							ptr_r   <= ptr_inc(ptr_r);
							state_r <= TWRP_WDATA_ACK;
							drive_r <= 1'h1;
						end
						else
							state_r <= TWRP_IDLE;
					end
				TWRP_RDATA:
					if (scl_fall)
					begin
						if (bit_cnt_r == `TWRP_TX_LAST)
						begin
							state_r <= TWRP_RDATA_ACK;
							drive_r <= 1'h0;
							ptr_r   <= ptr_inc(ptr_r);
						end
						else
						begin
							shift_r   <= {shift_r[6:0], 1'h0};
							drive_r   <= ~shift_r[6];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				TWRP_RDATA_ACK:
				begin
					if (scl_rise)
						mack_r <= ~line_r[1];
					if (scl_fall)
					begin
						bit_cnt_r <= 4'h0;
						if (mack_r)
						begin
							state_r <= TWRP_RDATA;
							shift_r <= rd_hold_r;
							drive_r <= ~rd_hold_r[7];
						end
						else
							state_r <= TWRP_IDLE;
					end
				end
				default:
				begin
					state_r <= TWRP_IDLE;
					drive_r <= 1'h0;
				end
			endcase
		end
	end

	// Open drain: only ever pull low
	assign o_sda_out  = 1'h0;
	assign o_sda_oe_n = ~drive_r;

	// =====================================================
	// Request handshake toward the register domain
	logic                    req_tgl_r;
	logic                    req_wr_r;
	logic [`TWRP_REG_AW-1:0] req_addr_r;
	twrp_byte_t              req_data_r;
	logic                    ack_s1_r;
	logic                    ack_s2_r;
	logic                    ack_tgl_r;

	always_ff @(posedge i_link_clock or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			req_tgl_r  <= 1'h0;
			req_wr_r   <= 1'h0;
			req_addr_r <= '0;
			req_data_r <= 8'h00;
			ack_s1_r   <= 1'h0;
			ack_s2_r   <= 1'h0;
		end
		else
		begin
			ack_s1_r <= ack_tgl_r;
			ack_s2_r <= ack_s1_r;
			if (wr_fire || rd_fire)
			begin
				req_tgl_r  <= ~req_tgl_r;
				req_wr_r   <= wr_fire;
				req_addr_r <= wr_fire ? ptr_r[`TWRP_REG_AW-1:0] : rd_addr;
				req_data_r <= shift_r;
			end
		end
	end

	assign busy = ack_s2_r ^ req_tgl_r;

	// =====================================================
	// Register domain
	logic       req_s1_r;
	logic       req_s2_r;
	logic       req_s3_r;
	logic       core_req;
	logic       rd_pend_r;
	twrp_byte_t mem_a_data;

	always_ff @(posedge i_clock or negedge core_rstn)
	begin
		if (!core_rstn)
		begin
			req_s1_r <= 1'h0;
			req_s2_r <= 1'h0;
			req_s3_r <= 1'h0;
		end
		else
		begin
			req_s1_r <= req_tgl_r;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
		end
	end

	assign core_req = req_s2_r ^ req_s3_r;

	always_ff @(posedge i_clock or negedge core_rstn)
	begin
		if (!core_rstn)
		begin
			rd_pend_r <= 1'h0;
			ack_tgl_r <= 1'h0;
			rd_hold_r <= `TWRP_REG_DEFAULT;
		end
		else
		begin
			rd_pend_r <= core_req & ~req_wr_r;
			if (core_req && req_wr_r)
				ack_tgl_r <= ~ack_tgl_r;
			else if (rd_pend_r)
			begin
				ack_tgl_r <= ~ack_tgl_r;
				rd_hold_r <= mem_a_data;
			end
		end
	end

	twrp_regmem u_regmem
	(
		.i_clock   (i_clock),
		.i_rstn    (core_rstn),
		.i_wr_en   (core_req & req_wr_r),
		.i_a_addr  (req_addr_r),
		.i_wr_data (req_data_r),
		.o_a_data  (mem_a_data),
		.i_b_addr  (i_core_addr),
		.o_b_data  (o_core_data)
	);

	// =====================================================
	// Checks
	AST_SDA_LOW_ONLY:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		o_sda_out == 1'h0
		&& (o_sda_oe_n || state_r inside {TWRP_ADDR_ACK, TWRP_PTR_ACK, TWRP_WDATA_ACK, TWRP_RDATA}))
	else $error("data line driven other than low");

	AST_START_RESTART:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		start_cond |=> state_r == TWRP_ADDR && bit_cnt_r == 4'h0 && o_sda_oe_n)
	else $error("start did not restart address phase");

	AST_STOP_IDLE:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(stop_cond && !start_cond) |=> state_r == TWRP_IDLE && o_sda_oe_n)
	else $error("stop did not return to idle");

	AST_ADDR_ACK:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(state_r == TWRP_ADDR && byte_done && addr_match && !cond) |=> !o_sda_oe_n [*1] ##0 state_r == TWRP_ADDR_ACK)
	else $error("own address not acknowledged");

	AST_MISMATCH:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(state_r == TWRP_ADDR && byte_done && !addr_match && !cond) |=> state_r == TWRP_IDLE && o_sda_oe_n)
	else $error("foreign address not ignored");

	AST_STRAP_BIT:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(state_r == TWRP_ADDR_ACK && !o_sda_oe_n) |-> shift_r[2] == strap)
	else $error("address bit one differs from strap");

	AST_DIRECTION:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(state_r == TWRP_ADDR && byte_done && addr_match && !cond) |=> rw_r == $past(shift_r[0]))
	else $error("direction bit not captured");

	AST_BAD_POINTER:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(state_r == TWRP_PTR && byte_done && !ptr_valid(shift_r[6:0]) && !cond)
		|=> state_r == TWRP_IDLE ##1 o_sda_oe_n)
	else $error("invalid pointer acknowledged");

	AST_WRITE_OVERRUN:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(state_r == TWRP_WDATA && byte_done && !ptr_valid(ptr_r) && !cond)
		|=> state_r == TWRP_IDLE && $stable(req_tgl_r))
	else $error("overrun write not discarded");

	AST_READ_SATURATE:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(rd_fire && ptr_r >= `TWRP_REG_LAST) |=> req_addr_r == `TWRP_REG_LAST)
	else $error("read address beyond highest register");

	AST_MASTER_NACK:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		(state_r == TWRP_RDATA_ACK && scl_fall && !mack_r && !cond) |=> state_r == TWRP_IDLE)
	else $error("read continued after no-acknowledge");

	AST_READ_READY:
	assert property (@(posedge i_link_clock) disable iff (!link_rstn)
		rd_fire |-> ##[1:40] !busy)
	else $error("read request not answered in time");

endmodule : twrp_top

// >>> sim/twrp_bus_master.sv
// Purpose: Behavioural two-wire bus master facing the register port
// Assumes: Data wire pull-up resolved in the bench
// Notes:   Bus tasks are called from the bench by hierarchy
`timescale 1ns/100ps

module twrp_bus_master
#(
	parameter int P_HALF = 30                    // Link clocks per SCL half period
)
(
	input  wire logic i_link_clock,              // Timing reference
	input  wire logic i_sda,                     // Resolved data wire
	output logic      o_scl,                     // Serial clock, idles high
	output logic      o_sda_low                  // High pulls data low
);
	initial
	begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_link_clock);
	endtask : wait_clk

	// Data moves a quarter of a half period after SCL falls
	task automatic set_sda(input logic low);
		wait_clk(P_HALF / 4);
		o_sda_low <= low;
	endtask : set_sda

	task automatic pulse(output logic smp);
		wait_clk(P_HALF);
		o_scl <= 1'b1;
		wait_clk(P_HALF);
		smp = i_sda;
		o_scl <= 1'b0;
	endtask : pulse

	task automatic start_cond;
		set_sda(1'b0);
		wait_clk(P_HALF);
		o_scl <= 1'b1;
		wait_clk(P_HALF);
		o_sda_low <= 1'b1;
		wait_clk(P_HALF);
		o_scl <= 1'b0;
	endtask : start_cond

	task automatic stop_cond;
		set_sda(1'b1);
		wait_clk(P_HALF);
		o_scl <= 1'b1;
		wait_clk(P_HALF);
		o_sda_low <= 1'b0;
		wait_clk(P_HALF);
	endtask : stop_cond

	// Short SCL spike on demand inside the first bit
	task automatic send_bits(input logic [7:0] v, input int n, input logic glitch, output logic ack);
		logic s;
		ack = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			set_sda(!v[7-i]);
			if (glitch && i == 0)
			begin
				wait_clk(2);
				o_scl <= 1'b1;
				#30 o_scl <= 1'b0;
			end
			pulse(s);
		end
		if (n == 8)
		begin
			set_sda(1'b0);
			pulse(s);
			ack = !s;
		end
	endtask : send_bits

	task automatic recv_byte(input logic nack, output logic [7:0] v);
		logic s;
		set_sda(1'b0);
		for (int i = 0; i < 8; i++)
		begin
			pulse(s);
			v = {v[6:0], s};
		end
		set_sda(!nack);
		pulse(s);
	endtask : recv_byte

endmodule : twrp_bus_master

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the two-wire register port
// Assumes: Bus master model drives SCL and shares SDA
// Notes:   Reset check first, then row loop, awkward cases after
`timescale 1ns/100ps
`include "twrp_map.svh"

module tb_top;
	import twrp_pkg::*;

	localparam logic [6:0] BASE        = 7'h2C;
	localparam logic [7:0] ROW_PTR [4] = '{8'h00, 8'h1F, 8'h10, 8'h07};
	localparam logic [7:0] ROW_DAT [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h81};

	logic                    i_clock;
	logic                    i_resetn;
	logic                    i_link_clock;
	logic                    scl;
	logic                    sda_low;
	logic                    o_sda_out;
	logic                    o_sda_oe_n;
	logic                    i_address_strap_pin;
	logic [`TWRP_REG_AW-1:0] i_core_addr;
	twrp_byte_t              o_core_data;
	wire                     sda;
	int                      errors;
	int                      n_tests;

	// Open-drain wire with pull-up
	assign sda = (!o_sda_oe_n || sda_low) ? 1'b0 : 1'b1;

	always #5 i_clock = ~i_clock;
	always #6 i_link_clock = ~i_link_clock;

	twrp_top #(.P_ADDR_BASE(BASE)) twrp_top_i
	(
		.i_clock             (i_clock),
		.i_resetn            (i_resetn),
		.i_link_clock        (i_link_clock),
		.i_scl               (scl),
		.i_sda               (sda),
		.o_sda_out           (o_sda_out),
		.o_sda_oe_n          (o_sda_oe_n),
		.i_address_strap_pin (i_address_strap_pin),
		.i_core_addr         (i_core_addr),
		.o_core_data         (o_core_data)
	);

	twrp_bus_master #(.P_HALF(30)) twrp_bus_master_i
	(
		.i_link_clock (i_link_clock),
		.i_sda        (sda),
		.o_scl        (scl),
		.o_sda_low    (sda_low)
	);

	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	function automatic logic [7:0] abyte(input logic rw);
		return {BASE[6:2], i_address_strap_pin, BASE[0], rw};
	endfunction : abyte

	task automatic put(input logic [7:0] v, input logic exp_ack, input string name);
		logic ack;
		twrp_bus_master_i.send_bits(v, 8, 1'b0, ack);
		check(name, {7'h00, ack}, {7'h00, exp_ack});
	endtask : put

	task automatic wr_seq(input logic [7:0] ptr, input logic [7:0] q[$]);
		twrp_bus_master_i.start_cond();
		put(abyte(1'b0), 1'b1, "write address ack");
		put(ptr, ptr <= 8'h1F, "pointer ack");
		if (ptr <= 8'h1F)
			foreach (q[i])
				put(q[i], (ptr + i) <= 8'h1F, "data ack");
		twrp_bus_master_i.stop_cond();
	endtask : wr_seq

	task automatic rd_seq(input logic [7:0] ptr, input logic [7:0] q[$]);
		logic [7:0] v;
		twrp_bus_master_i.start_cond();
		put(abyte(1'b0), 1'b1, "pointer phase ack");
		put(ptr, 1'b1, "pointer ack");
		twrp_bus_master_i.start_cond();
		put(abyte(1'b1), 1'b1, "read address ack");
		foreach (q[i])
		begin
			twrp_bus_master_i.recv_byte(i == q.size() - 1, v);
			check("read data", v, q[i]);
		end
		twrp_bus_master_i.stop_cond();
	endtask : rd_seq

	task automatic core_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge i_clock);
		i_core_addr <= a[4:0];
		repeat (3) @(posedge i_clock);
		@(negedge i_clock);
		check(name, o_core_data, exp);
	endtask : core_chk

	task automatic probe(input logic [7:0] a, input logic glitch, input logic exp_ack);
		logic ack;
		twrp_bus_master_i.start_cond();
		twrp_bus_master_i.send_bits(a, 8, glitch, ack);
		twrp_bus_master_i.stop_cond();
		check("address probe ack", {7'h00, ack}, {7'h00, exp_ack});
	endtask : probe

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#900000;
		errors++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial
	begin
		logic ack;
		i_clock             = 1'b0;
		i_link_clock        = 1'b0;
		i_resetn            = 1'b0;
		i_address_strap_pin = 1'b0;
		i_core_addr         = '0;
		errors              = 0;
		n_tests             = 0;
		repeat (10) @(posedge i_clock);
		i_resetn <= 1'b1;
		repeat (10) @(posedge i_clock);
		core_chk(8'h05, 8'h00, "reset default");
		check("idle data pin", {7'h00, o_sda_oe_n}, 8'h01);
		$display("test reset done");
		for (int r = 0; r < 4; r++)
		begin
			wr_seq(ROW_PTR[r], {ROW_DAT[r]});
			core_chk(ROW_PTR[r], ROW_DAT[r], "core view");
			rd_seq(ROW_PTR[r], {ROW_DAT[r]});
		end
		check("pin output level", {7'h00, o_sda_out}, 8'h00);
		$display("test rows done");
		wr_seq(8'h1E, {8'h5A, 8'hC3, 8'h77});
		core_chk(8'h1E, 8'h5A, "autoinc first");
		core_chk(8'h1F, 8'hC3, "autoinc second");
		core_chk(8'h00, 8'hA5, "excess discarded");
		rd_seq(8'h1E, {8'h5A, 8'hC3, 8'hC3, 8'hC3});
		$display("test autoincrement done");
		probe({BASE ^ 7'h40, 1'b0}, 1'b0, 1'b0);
		probe({BASE | 7'h02, 1'b0}, 1'b0, 1'b0);
		wr_seq(8'h20, {8'h99});
		$display("test refusals done");
		twrp_bus_master_i.start_cond();
		put(abyte(1'b0), 1'b1, "abort address ack");
		put(8'h10, 1'b1, "abort pointer ack");
		twrp_bus_master_i.send_bits(8'h00, 4, 1'b0, ack);
		twrp_bus_master_i.start_cond();
		put(abyte(1'b0), 1'b1, "restart address ack");
		put(8'h11, 1'b1, "restart pointer ack");
		put(8'h66, 1'b1, "restart data ack");
		twrp_bus_master_i.stop_cond();
		core_chk(8'h10, 8'hFF, "aborted byte dropped");
		core_chk(8'h11, 8'h66, "restart write");
		$display("test abort done");
		@(posedge i_clock);
		i_address_strap_pin <= 1'b1;
		repeat (20) @(posedge i_clock);
		probe({BASE | 7'h02, 1'b0}, 1'b1, 1'b1);
		rd_seq(8'h07, {8'h81});
		@(posedge i_clock);
		i_address_strap_pin <= 1'b0;
		repeat (20) @(posedge i_clock);
		probe({BASE, 1'b0}, 1'b1, 1'b0);
		$display("test strap done");
		@(posedge i_clock);
		i_resetn <= 1'b0;
		repeat (10) @(posedge i_clock);
		i_resetn <= 1'b1;
		repeat (10) @(posedge i_clock);
		core_chk(8'h07, 8'h00, "second reset default");
		$display("test second reset done");
		tally_and_finish();
	end

endmodule : tb_top
